//--- hdl/daqlb_pkg.sv
// Purpose: shared offsets, indices and reset values for the local bus register decode
// Assumes: control window byte addresses, fifo window byte addresses
// Notes:   offsets are byte addresses; bits [1:0] of an address never take part in a match
package daqlb_pkg;

    localparam int CTRL_AW = 9;
    localparam int FIFO_AW = 4;
    localparam int PACER_W = 24;
    localparam int FIFO_DW = 16;
    localparam int BUS_DW  = 32;

    // control window, runtime area
    localparam logic [8:0] OFS_USER_IO    = 9'h008;
    localparam logic [8:0] OFS_DAC_CLK    = 9'h00c;
    localparam logic [8:0] OFS_FIFO_STAT  = 9'h010;
    localparam logic [8:0] OFS_DAC1_UPD   = 9'h014;
    localparam logic [8:0] OFS_DAC2_UPD   = 9'h018;
    localparam logic [8:0] OFS_DAC_BOTH   = 9'h024;
    localparam logic [8:0] OFS_PACER_SS   = 9'h028;
    localparam logic [8:0] OFS_TIMER_HS   = 9'h02c;
    localparam logic [8:0] OFS_IRQ_STAT   = 9'h030;
    localparam logic [8:0] OFS_IRQ_CLR    = 9'h034;
    localparam logic [8:0] OFS_IRQ_OVR    = 9'h038;
    localparam logic [8:0] OFS_PACER_CNT  = 9'h040;

    // fifo data window
    localparam logic [3:0] OFS_ADC_FIFO   = 4'h0;
    localparam logic [3:0] OFS_HSDI_FIFO  = 4'h4;
    localparam logic [3:0] OFS_DAC1_FIFO  = 4'h8;
    localparam logic [3:0] OFS_DAC2_FIFO  = 4'hc;

    // positions in the decoder hit vectors
    localparam int NUM_CTRL       = 12;
    localparam int IDX_USER_IO    = 0;
    localparam int IDX_DAC_CLK    = 1;
    localparam int IDX_FIFO_STAT  = 2;
    localparam int IDX_DAC1_UPD   = 3;
    localparam int IDX_DAC2_UPD   = 4;
    localparam int IDX_DAC_BOTH   = 5;
    localparam int IDX_PACER_SS   = 6;
    localparam int IDX_TIMER_HS   = 7;
    localparam int IDX_IRQ_STAT   = 8;
    localparam int IDX_IRQ_CLR    = 9;
    localparam int IDX_IRQ_OVR    = 10;
    localparam int IDX_PACER_CNT  = 11;
    localparam int NUM_FIFO       = 4;
    localparam int IDX_ADC_FIFO   = 0;
    localparam int IDX_HSDI_FIFO  = 1;
    localparam int IDX_DAC1_FIFO  = 2;
    localparam int IDX_DAC2_FIFO  = 3;

    // reset values
    localparam logic [31:0] USER_OUT_RST  = 32'h0000_0000;
    localparam logic [31:0] IRQ_MASK_RST  = 32'h0000_0000;
    localparam logic [31:0] IRQ_CLR_RST   = 32'h0000_0000;
    localparam logic [23:0] PACER_LD_RST  = 24'h00_0000;

endpackage

//--- hdl/daqlb_addr_decode.sv
// Purpose: one-hot word address match against a table of offsets
// Assumes: offsets are word aligned byte addresses
// Notes:   address bits [AW-1:2] compared, so only byte addresses inside a table word alias; others never hit
`timescale 1ns/1ns
`default_nettype none
module daqlb_addr_decode #(
    parameter int              N       = 4,
    parameter int              AW      = 4,
    parameter logic [N*AW-1:0] OFFSETS = '0
) (
    input  wire logic [AW-1:0] addr,
    input  wire logic          sel,
    output logic      [N-1:0]  hit
);

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_hit
            assign hit[i] = sel && (addr[AW-1:2] == OFFSETS[i*AW+2 +: AW-2]);
        end
    endgenerate

endmodule
`default_nettype wire

//--- hdl/daqlb_hold_reg.sv
// Purpose: loadable holding register with a reset value
// Assumes: load is a single cycle qualifier
// Notes:   used for the user outputs, the interrupt enable mask and the interrupt clear mask
`timescale 1ns/1ns
`default_nettype none
module daqlb_hold_reg #(
    parameter int         W   = 8,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            q <= RST;
        else if (load)
            q <= d;
    end

endmodule
`default_nettype wire

//--- hdl/daqlb_local_bus_regs.sv
// Purpose: local bus decode of the control window runtime area and the fifo data window
// Assumes: single cycle accesses from the bridge, one of lb_rd or lb_wr per cycle
// Notes:   read data and control strobes appear one cycle after the access
`timescale 1ns/1ns
`default_nettype none
module daqlb_local_bus_regs #(
    parameter int UIO_W = 8,
    parameter int IRQ_W = 16
) (
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    input  wire logic                    ctrl_sel,
    input  wire logic                    fifo_sel,
    input  wire logic [8:0]              lb_addr,
    input  wire logic                    lb_rd,
    input  wire logic                    lb_wr,
    input  wire logic [31:0]             lb_wdata,
    output logic      [31:0]             lb_rdata,
    output logic                         lb_ack,
    input  wire logic [UIO_W-1:0]        user_in,
    output logic      [UIO_W-1:0]        user_out,
    input  wire logic [31:0]             fifo_status,
    input  wire logic [31:0]             timer_status,
    input  wire logic [IRQ_W-1:0]        irq_pending,
    input  wire logic [IRQ_W-1:0]        irq_overrun,
    input  wire logic [23:0]             pacer_count,
    input  wire logic [15:0]             adc_fifo_dout,
    input  wire logic [15:0]             hsdi_fifo_dout,
    output logic                         dac_clk_start,
    output logic                         dac_clk_stop,
    output logic                         adc_sw_start,
    output logic                         dac1_update,
    output logic                         dac2_update,
    output logic                         pacer_start,
    output logic                         pacer_stop,
    output logic                         hsdi_sample,
    output logic      [IRQ_W-1:0]        irq_enable_mask,
    output logic      [IRQ_W-1:0]        irq_clear,
    output logic                         overrun_clear,
    output logic                         pacer_load,
    output logic      [23:0]             pacer_load_value,
    output logic                         adc_fifo_pop,
    output logic                         hsdi_fifo_pop,
    output logic                         dac1_fifo_push,
    output logic                         dac2_fifo_push,
    output logic      [15:0]             dac_fifo_wdata
);

    localparam logic [daqlb_pkg::NUM_CTRL*daqlb_pkg::CTRL_AW-1:0] CTRL_TABLE = {
        daqlb_pkg::OFS_PACER_CNT, daqlb_pkg::OFS_IRQ_OVR,   daqlb_pkg::OFS_IRQ_CLR,
        daqlb_pkg::OFS_IRQ_STAT,  daqlb_pkg::OFS_TIMER_HS,  daqlb_pkg::OFS_PACER_SS,
        daqlb_pkg::OFS_DAC_BOTH,  daqlb_pkg::OFS_DAC2_UPD,  daqlb_pkg::OFS_DAC1_UPD,
        daqlb_pkg::OFS_FIFO_STAT, daqlb_pkg::OFS_DAC_CLK,   daqlb_pkg::OFS_USER_IO
    };
    localparam logic [daqlb_pkg::NUM_FIFO*daqlb_pkg::FIFO_AW-1:0] FIFO_TABLE = {
        daqlb_pkg::OFS_DAC2_FIFO, daqlb_pkg::OFS_DAC1_FIFO,
        daqlb_pkg::OFS_HSDI_FIFO, daqlb_pkg::OFS_ADC_FIFO
    };

    logic [daqlb_pkg::NUM_CTRL-1:0] c_hit;
    logic [daqlb_pkg::NUM_FIFO-1:0] f_hit;
    logic                           ctrl_rd;
    logic                           ctrl_wr;
    logic                           fifo_rd;
    logic                           fifo_wr;
    logic [31:0]                    ctrl_word;
    logic [31:0]                    fifo_word;
    logic [31:0]                    next_rdata;
    logic                           rd_taken;
    logic [IRQ_W-1:0]               irq_clr_mask;
    logic [UIO_W-1:0]               wdata_uio;
    logic [IRQ_W-1:0]               wdata_irq;

    // offset bits [8:2] compared: setup area and reserved words never hit
    daqlb_addr_decode #(
        .N       (daqlb_pkg::NUM_CTRL),
        .AW      (daqlb_pkg::CTRL_AW),
        .OFFSETS (CTRL_TABLE)
    ) u_ctrl_dec (
        .addr (lb_addr),
        .sel  (ctrl_sel),
        .hit  (c_hit)
    );

    daqlb_addr_decode #(
        .N       (daqlb_pkg::NUM_FIFO),
        .AW      (daqlb_pkg::FIFO_AW),
        .OFFSETS (FIFO_TABLE)
    ) u_fifo_dec (
        .addr (lb_addr[3:0]),
        .sel  (fifo_sel),
        .hit  (f_hit)
    );

    assign ctrl_rd   = ctrl_sel & lb_rd;
    assign ctrl_wr   = ctrl_sel & lb_wr;
    assign fifo_rd   = fifo_sel & lb_rd;
    assign fifo_wr   = fifo_sel & lb_wr;
    assign wdata_uio = lb_wdata[UIO_W-1:0];
    assign wdata_irq = lb_wdata[IRQ_W-1:0];

    // every access completes in its own cycle, no wait states
    assign lb_ack = (ctrl_sel | fifo_sel) & (lb_rd | lb_wr);

    // read selection; unmatched and write-only offsets fall through to zero
    assign ctrl_word =
        c_hit[daqlb_pkg::IDX_USER_IO]   ? {{(32-UIO_W){1'b0}}, user_in} :
        c_hit[daqlb_pkg::IDX_FIFO_STAT] ? fifo_status :
        c_hit[daqlb_pkg::IDX_TIMER_HS]  ? timer_status :
        c_hit[daqlb_pkg::IDX_IRQ_STAT]  ? {{(32-IRQ_W){1'b0}}, irq_pending} :
        c_hit[daqlb_pkg::IDX_IRQ_CLR]   ? {{(32-IRQ_W){1'b0}}, irq_clr_mask} :
        c_hit[daqlb_pkg::IDX_IRQ_OVR]   ? {{(32-IRQ_W){1'b0}}, irq_overrun} :
        c_hit[daqlb_pkg::IDX_PACER_CNT] ? {8'h00, pacer_count} :
        32'h0000_0000;

    assign fifo_word =
        f_hit[daqlb_pkg::IDX_ADC_FIFO]  ? {16'h0000, adc_fifo_dout} :
        f_hit[daqlb_pkg::IDX_HSDI_FIFO] ? {16'h0000, hsdi_fifo_dout} :
        32'h0000_0000;

    assign rd_taken   = ctrl_rd | fifo_rd;
    assign next_rdata = ctrl_rd ? ctrl_word : fifo_word;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            lb_rdata <= 32'h0000_0000;
        else if (rd_taken)
            lb_rdata <= next_rdata;
    end

    // pops are combinational so a back-to-back read sees the next word, not a repeat
    assign adc_fifo_pop  = fifo_rd & f_hit[daqlb_pkg::IDX_ADC_FIFO];
    assign hsdi_fifo_pop = fifo_rd & f_hit[daqlb_pkg::IDX_HSDI_FIFO];

    daqlb_hold_reg #(
        .W   (UIO_W),
        .RST (daqlb_pkg::USER_OUT_RST[UIO_W-1:0])
    ) u_user_out (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .load    (ctrl_wr & c_hit[daqlb_pkg::IDX_USER_IO]),
        .d       (wdata_uio),
        .q       (user_out)
    );

    daqlb_hold_reg #(
        .W   (IRQ_W),
        .RST (daqlb_pkg::IRQ_MASK_RST[IRQ_W-1:0])
    ) u_irq_mask (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .load    (ctrl_wr & c_hit[daqlb_pkg::IDX_IRQ_STAT]),
        .d       (wdata_irq),
        .q       (irq_enable_mask)
    );

    daqlb_hold_reg #(
        .W   (IRQ_W),
        .RST (daqlb_pkg::IRQ_CLR_RST[IRQ_W-1:0])
    ) u_irq_clr_mask (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .load    (ctrl_wr & c_hit[daqlb_pkg::IDX_IRQ_CLR]),
        .d       (wdata_irq),
        .q       (irq_clr_mask)
    );

    // control strobes: one-cycle pulses in the cycle after the access
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dac_clk_start <= 1'b0;
            dac_clk_stop  <= 1'b0;
            adc_sw_start  <= 1'b0;
            dac1_update   <= 1'b0;
            dac2_update   <= 1'b0;
            pacer_start   <= 1'b0;
            pacer_stop    <= 1'b0;
            hsdi_sample   <= 1'b0;
            irq_clear     <= '0;
            overrun_clear <= 1'b0;
        end
        else
        begin
            dac_clk_start <= ctrl_rd & c_hit[daqlb_pkg::IDX_DAC_CLK];
            dac_clk_stop  <= ctrl_wr & c_hit[daqlb_pkg::IDX_DAC_CLK];
            adc_sw_start  <= ctrl_wr & c_hit[daqlb_pkg::IDX_FIFO_STAT];
            dac1_update   <= ctrl_wr & (c_hit[daqlb_pkg::IDX_DAC1_UPD]
                                        | c_hit[daqlb_pkg::IDX_DAC_BOTH]);
            dac2_update   <= ctrl_wr & (c_hit[daqlb_pkg::IDX_DAC2_UPD]
                                        | c_hit[daqlb_pkg::IDX_DAC_BOTH]);
            pacer_start   <= ctrl_rd & c_hit[daqlb_pkg::IDX_PACER_SS];
            pacer_stop    <= ctrl_wr & c_hit[daqlb_pkg::IDX_PACER_SS];
            hsdi_sample   <= ctrl_wr & c_hit[daqlb_pkg::IDX_TIMER_HS];
            irq_clear     <= (ctrl_rd & c_hit[daqlb_pkg::IDX_IRQ_CLR]) ? irq_clr_mask : '0;
            overrun_clear <= ctrl_wr & c_hit[daqlb_pkg::IDX_IRQ_OVR];
        end
    end

    // pacer load word and dac fifo pushes, registered with their data
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pacer_load       <= 1'b0;
            pacer_load_value <= daqlb_pkg::PACER_LD_RST;
            dac1_fifo_push   <= 1'b0;
            dac2_fifo_push   <= 1'b0;
            dac_fifo_wdata   <= 16'h0000;
        end
        else
        begin
            pacer_load     <= ctrl_wr & c_hit[daqlb_pkg::IDX_PACER_CNT];
            dac1_fifo_push <= fifo_wr & f_hit[daqlb_pkg::IDX_DAC1_FIFO];
            dac2_fifo_push <= fifo_wr & f_hit[daqlb_pkg::IDX_DAC2_FIFO];
            if (ctrl_wr & c_hit[daqlb_pkg::IDX_PACER_CNT])
                pacer_load_value <= lb_wdata[23:0];
            // only the low lane is taken, the window is a 16-bit port
            if (fifo_wr)
                dac_fifo_wdata <= lb_wdata[15:0];
        end
    end

    AST_ACK_SAME_CYCLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_sel && (lb_rd || lb_wr)) |-> lb_ack)
        else $error("access not acknowledged in its own cycle");

    AST_USER_OUT_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_USER_IO) |=> user_out == $past(wdata_uio))
        else $error("user outputs did not take the written value");

    AST_DAC_CLK_START: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && lb_addr == daqlb_pkg::OFS_DAC_CLK) |=> dac_clk_start && !dac_clk_stop)
        else $error("dac clock start not pulsed on read");

    AST_ADC_START_ONCE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_FIFO_STAT) ##1 !lb_wr
        |-> adc_sw_start ##1 !adc_sw_start)
        else $error("software conversion start not a single pulse");

    AST_DAC_BOTH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_DAC_BOTH) |=> dac1_update && dac2_update)
        else $error("simultaneous update missed an output");

    AST_PACER_STOP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_PACER_SS) |=> pacer_stop && !pacer_start)
        else $error("pacer stop not pulsed on write");

    AST_HSDI_SAMPLE: assert property (@(posedge ref_clk) disable iff (!arst_n)
        hsdi_sample |-> $past(ctrl_wr && lb_addr[8:2] == daqlb_pkg::OFS_TIMER_HS[8:2]))
        else $error("input sample without a write to its offset");

    AST_IRQ_MASK_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !(ctrl_wr && lb_addr[8:2] == daqlb_pkg::OFS_IRQ_STAT[8:2]) |=> $stable(irq_enable_mask))
        else $error("interrupt enable mask changed without a write");

    AST_IRQ_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && lb_addr == daqlb_pkg::OFS_IRQ_CLR) |=> irq_clear == $past(irq_clr_mask))
        else $error("interrupt clear does not follow the stored mask");

    AST_OVERRUN_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_IRQ_OVR) |=> overrun_clear)
        else $error("overrun flags not cleared on write");

    AST_PACER_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_PACER_CNT)
        |=> pacer_load && pacer_load_value == $past(lb_wdata[23:0]))
        else $error("pacer counter load word wrong");

    AST_ADC_READ_DATA: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fifo_rd && lb_addr[3:0] == daqlb_pkg::OFS_ADC_FIFO)
        |-> adc_fifo_pop ##1 lb_rdata == {16'h0000, $past(adc_fifo_dout)})
        else $error("sample fifo read returned the wrong word");

    AST_DAC2_PUSH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fifo_wr && lb_addr[3:0] == daqlb_pkg::OFS_DAC2_FIFO)
        |=> dac2_fifo_push && !dac1_fifo_push)
        else $error("second dac fifo push missing");

    AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && c_hit == '0) |=> lb_rdata == 32'h0000_0000)
        else $error("reserved offset did not read zero");

    AST_DAC_CLK_STOP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_DAC_CLK) |=> dac_clk_stop && !dac_clk_start)
        else $error("dac clock stop not pulsed on write");

    AST_FIFO_STAT_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && lb_addr == daqlb_pkg::OFS_FIFO_STAT)
        |=> lb_rdata == $past(fifo_status) && !adc_sw_start)
        else $error("fifo status read wrong");

    AST_TIMER_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && lb_addr == daqlb_pkg::OFS_TIMER_HS)
        |=> lb_rdata == $past(timer_status) && !hsdi_sample)
        else $error("timer status read wrong");

    AST_IRQ_MASK_LOAD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && lb_addr == daqlb_pkg::OFS_IRQ_STAT) |=> irq_enable_mask == $past(wdata_irq))
        else $error("interrupt enable mask did not load");

    AST_IRQ_CLR_QUIET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (irq_clear != '0) |-> $past(ctrl_rd && lb_addr[8:2] == daqlb_pkg::OFS_IRQ_CLR[8:2]))
        else $error("interrupt clear without a read of its offset");

    AST_OVERRUN_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && lb_addr == daqlb_pkg::OFS_IRQ_OVR)
        |=> lb_rdata == {{(32-IRQ_W){1'b0}}, $past(irq_overrun)})
        else $error("overrun flags read wrong");

    AST_PACER_READ: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_rd && lb_addr == daqlb_pkg::OFS_PACER_CNT) |=> lb_rdata == {8'h00, $past(pacer_count)})
        else $error("pacer counter read wrong");

    AST_HSDI_READ_DATA: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fifo_rd && lb_addr[3:0] == daqlb_pkg::OFS_HSDI_FIFO)
        |-> hsdi_fifo_pop ##1 lb_rdata == {16'h0000, $past(hsdi_fifo_dout)})
        else $error("input fifo read returned the wrong word");

    AST_DAC1_PUSH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fifo_wr && lb_addr[3:0] == daqlb_pkg::OFS_DAC1_FIFO)
        |=> dac1_fifo_push && dac_fifo_wdata == $past(lb_wdata[15:0]))
        else $error("first dac fifo push or data wrong");

    AST_RESERVED_QUIET: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (ctrl_wr && c_hit == '0) |=> {dac_clk_stop, adc_sw_start, dac1_update, dac2_update,
        pacer_stop, hsdi_sample, overrun_clear, pacer_load} == 8'h00)
        else $error("reserved write caused a side effect");

endmodule
`default_nettype wire

//--- verification/daqlb_bridge_model.sv
// Purpose: bridge side bus master model driving the local bus windows
// Assumes: tasks are entered right after a rising edge of ref_clk
// Notes:   one beat per call, no bursts; released lines show inverted junk
`timescale 1ns/1ns
`default_nettype none
module daqlb_bridge_model (
    input  wire logic        ref_clk,
    output logic             ctrl_sel,
    output logic             fifo_sel,
    output logic      [8:0]  lb_addr,
    output logic             lb_rd,
    output logic             lb_wr,
    output logic      [31:0] lb_wdata
);
    initial
    begin
        ctrl_sel = 1'b0;
        fifo_sel = 1'b0;
        lb_rd    = 1'b0;
        lb_wr    = 1'b0;
        lb_addr  = 9'h0;
        lb_wdata = 32'h0;
    end

    // zero wait states: the request is taken at the very next edge
    task automatic issue(input logic win, input logic wr, input logic [8:0] a,
                         input logic [31:0] d);
        ctrl_sel <= ~win;
        fifo_sel <= win;
        lb_rd    <= ~wr;
        lb_wr    <= wr;
        lb_addr  <= a;
        lb_wdata <= win ? {~d[15:0], d[15:0]} : d;
        @(posedge ref_clk);
    endtask

    // stale address and data must never look like a valid request
    task automatic release_bus();
        ctrl_sel <= 1'b0;
        fifo_sel <= 1'b0;
        lb_rd    <= 1'b0;
        lb_wr    <= 1'b0;
        lb_addr  <= ~lb_addr;
        lb_wdata <= ~lb_wdata;
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- verification/tb_daq_local_bus_register_decode.sv
// Purpose: self-checking bench for the local bus register decode
// Assumes: default widths of the decode, eight user lines, sixteen irq lines
// Notes:   registered results are checked one edge late, so accesses run back to back
`timescale 1ns/1ns
`default_nettype none
module tb_daq_local_bus_register_decode;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        ctrl_sel, fifo_sel, lb_rd, lb_wr, lb_ack, adc_fifo_pop, hsdi_fifo_pop;
    logic        dac_clk_start, dac_clk_stop, adc_sw_start, dac1_update, dac2_update;
    logic        pacer_start, pacer_stop, hsdi_sample, overrun_clear, pacer_load;
    logic        dac1_fifo_push, dac2_fifo_push;
    logic [8:0]  lb_addr;
    logic [31:0] lb_wdata, lb_rdata;
    logic [31:0] fifo_status = 32'h0, timer_status = 32'h0;
    logic [7:0]  user_in = 8'h0, user_out;
    logic [15:0] irq_pending = 16'h0, irq_overrun = 16'h0;
    logic [15:0] adc_fifo_dout = 16'h0, hsdi_fifo_dout = 16'h0;
    logic [15:0] irq_enable_mask, irq_clear, dac_fifo_wdata;
    logic [23:0] pacer_count = 24'h0, pacer_load_value;
    wire  logic [11:0] strb;
    logic [31:0] rs = 32'h27, p_rdata = 32'h0;
    logic [7:0]  m_uo = 8'h0;
    logic [15:0] m_mask = 16'h0, m_clr = 16'h0, p_clr = 16'h0, p_wd = 16'h0;
    logic [23:0] m_pl = 24'h0;
    logic [11:0] p_strb = 12'h0;
    logic        p_rd = 1'b0;
    int          failures = 0;
    int          n_compared = 0;

    assign strb = {dac_clk_start, dac_clk_stop, adc_sw_start, dac1_update, dac2_update,
                   pacer_start, pacer_stop, hsdi_sample, overrun_clear, pacer_load,
                   dac1_fifo_push, dac2_fifo_push};

    always #25 ref_clk = ~ref_clk;

    daqlb_bridge_model u_bridge (.ref_clk, .ctrl_sel, .fifo_sel, .lb_addr, .lb_rd, .lb_wr,
                                 .lb_wdata);

    daqlb_local_bus_regs DUT (.ref_clk, .arst_n, .ctrl_sel, .fifo_sel, .lb_addr, .lb_rd,
        .lb_wr, .lb_wdata, .lb_rdata, .lb_ack, .user_in, .user_out, .fifo_status,
        .timer_status, .irq_pending, .irq_overrun, .pacer_count, .adc_fifo_dout,
        .hsdi_fifo_dout, .dac_clk_start, .dac_clk_stop, .adc_sw_start, .dac1_update,
        .dac2_update, .pacer_start, .pacer_stop, .hsdi_sample, .irq_enable_mask, .irq_clear,
        .overrun_clear, .pacer_load, .pacer_load_value, .adc_fifo_pop, .hsdi_fifo_pop,
        .dac1_fifo_push, .dac2_fifo_push, .dac_fifo_wdata);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
    endfunction

    function automatic logic [11:0] exp_strb(input logic win, input logic wr,
                                             input logic [8:0] o);
        if (win)
            return {10'h0, wr & (o[3:0] == 4'h8), wr & (o[3:0] == 4'hc)};
        case (o)
            9'h00c: return wr ? 12'h400 : 12'h800;
            9'h010: return wr ? 12'h200 : 12'h0;
            9'h014: return wr ? 12'h100 : 12'h0;
            9'h018: return wr ? 12'h080 : 12'h0;
            9'h024: return wr ? 12'h180 : 12'h0;
            9'h028: return wr ? 12'h020 : 12'h040;
            9'h02c: return wr ? 12'h010 : 12'h0;
            9'h038: return wr ? 12'h008 : 12'h0;
            9'h040: return wr ? 12'h004 : 12'h0;
            default: return 12'h0;
        endcase
    endfunction

    function automatic logic [31:0] exp_rd(input logic win, input logic [8:0] o);
        if (win)
            return o[3:0] == 4'h0 ? {16'h0, adc_fifo_dout} :
                   o[3:0] == 4'h4 ? {16'h0, hsdi_fifo_dout} : 32'h0;
        case (o)
            9'h008: return {24'h0, user_in};
            9'h010: return fifo_status;
            9'h02c: return timer_status;
            9'h030: return {16'h0, irq_pending};
            9'h034: return {16'h0, m_clr};
            9'h038: return {16'h0, irq_overrun};
            9'h040: return {8'h0, pacer_count};
            default: return 32'h0;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // results of the access taken one edge earlier
    task automatic settle_check();
        chk({20'h0, strb}, {20'h0, p_strb});
        chk({16'h0, irq_clear}, {16'h0, p_clr});
        if (p_rd)
            chk(lb_rdata, p_rdata);
        if (p_strb[1] | p_strb[0])
            chk({16'h0, dac_fifo_wdata}, {16'h0, p_wd});
        chk({24'h0, user_out}, {24'h0, m_uo});
        chk({16'h0, irq_enable_mask}, {16'h0, m_mask});
        chk({8'h0, pacer_load_value}, {8'h0, m_pl});
    endtask

    task automatic access(input logic win, input logic wr, input logic [8:0] a);
        logic [31:0] d;
        logic [8:0]  o;
        rs = lfsr(rs);
        d = rs;
        o = {a[8:2], 2'b00};
        u_bridge.issue(win, wr, a, d);
        chk({31'h0, lb_ack}, 32'h1);
        chk({30'h0, adc_fifo_pop, hsdi_fifo_pop},
            {30'h0, win & ~wr & (o[3:0] == 4'h0), win & ~wr & (o[3:0] == 4'h4)});
        settle_check();
        p_strb = exp_strb(win, wr, o);
        p_clr = (!win && !wr && o == 9'h034) ? m_clr : 16'h0;
        p_rd = !wr;
        p_rdata = exp_rd(win, o);
        p_wd = d[15:0];
        if (wr && !win && o == 9'h008)
            m_uo = d[7:0];
        if (wr && !win && o == 9'h030)
            m_mask = d[15:0];
        if (wr && !win && o == 9'h034)
            m_clr = d[15:0];
        if (wr && !win && o == 9'h040)
            m_pl = d[23:0];
    endtask

    // idle cycle; status inputs change only here so reads see settled levels
    task automatic idle();
        rs = lfsr(rs);
        fifo_status <= rs;
        timer_status <= ~rs;
        irq_pending <= rs[31:16];
        irq_overrun <= rs[15:0];
        pacer_count <= rs[27:4];
        user_in <= rs[30:23];
        adc_fifo_dout <= rs[19:4];
        hsdi_fifo_dout <= ~rs[23:8];
        u_bridge.release_bus();
        chk({29'h0, lb_ack, adc_fifo_pop, hsdi_fifo_pop}, 32'h0);
        settle_check();
        p_strb = 12'h0;
        p_clr = 16'h0;
        p_rd = 1'b0;
    endtask

    task automatic conclude();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #(2000 * 50);
        failures++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        idle();
        // writes first so the clear mask is nonzero when it is read back
        for (int k = 0; k < 2; k++)
        begin
            for (int a = 0; a < 'h44; a += 4)
                access(1'b0, k == 0, a[8:0]);
            access(1'b0, k == 0, 9'h100);
            access(1'b0, k == 0, 9'h1ff);
            for (int a = 0; a < 16; a += 4)
                access(1'b1, k == 0, a[8:0] | k[1:0]);
            idle();
        end
        $display("test directed done");
        for (int i = 0; i < 300; i++)
        begin
            rs = lfsr(rs);
            if (rs[0])
                access(rs[1], rs[2], rs[1] ? {5'h0, rs[6:3]} : {rs[12] & rs[13], 2'b0, rs[9:4]});
            else
                idle();
        end
        $display("test random done");
        m_uo = 8'h0;
        m_mask = 16'h0;
        m_clr = 16'h0;
        m_pl = 24'h0;
        p_strb = 12'h0;
        p_clr = 16'h0;
        p_rd = 1'b0;
        arst_n <= 1'b0;
        idle();
        arst_n <= 1'b1;
        access(1'b0, 1'b0, 9'h034);
        access(1'b0, 1'b1, 9'h040);
        idle();
        $display("test reset done");
        conclude();
    end
endmodule
`default_nettype wire
